// ==== logic/sepr_pkg.sv ====
// shared constants and carrier types for the switch engine stats and priority remap bank
package sepr_pkg;

	// register indices as they appear on the management interface
	localparam logic [15:0] IDX_INGRESS_DROP_P2 = 16'h1852;
	localparam logic [15:0] IDX_REMAP_P0 = 16'h1855;
	localparam logic [15:0] IDX_REMAP_P1 = 16'h1856;
	localparam logic [15:0] IDX_REMAP_P2 = 16'h1857;
	localparam logic [15:0] IDX_UNLEARNED_P0 = 16'h1858;
	localparam logic [15:0] IDX_UNLEARNED_P1 = 16'h1859;
	localparam logic [15:0] IDX_UNLEARNED_P2 = 16'h185a;
	localparam logic [15:0] IDX_IRQ_GATE = 16'h1880;

	// counter limits and reset values
	localparam logic [31:0] CNT_RESET = 32'h0000_0000;
	localparam logic [31:0] CNT_MAX = 32'hffff_ffff;

	// remap table layout: eight 3-bit entries, entry n at bits 3n+2:3n
	localparam int NUM_PORTS = 3;
	localparam int NUM_PRIO = 8;
	localparam int PRIO_W = 3;
	localparam int TABLE_W = NUM_PRIO * PRIO_W;
	localparam logic [23:0] REMAP_RESET = 24'hfa_c688;

	// mask register: bit 0, set after reset
	localparam int IRQ_GATE_BIT = 0;
	localparam logic IRQ_GATE_RESET = 1'b1;

	// management access request
	typedef struct packed {
		logic rd;
		logic wr;
		logic [15:0] idx;
		logic [31:0] wdata;
	} sepr_req_t;

	// one frame priority lookup per port
	typedef struct packed {
		logic valid;
		logic [1:0] port;
		logic [2:0] prio;
	} sepr_prio_req_t;

	// priority result toward egress queue selection
	typedef struct packed {
		logic valid;
		logic [1:0] port;
		logic [2:0] prio;
	} sepr_prio_rsp_t;

endpackage

// ==== logic/sepr_sat_counter.sv ====
// saturating clear-on-read event counter
`timescale 1ns/1ps

module sepr_sat_counter
(
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// event and read-clear
	input wire logic event_pulse,
	input wire logic clear_on_read,
	// value
	output logic [31:0] count
);
	logic [31:0] count_reg;
	logic [31:0] count_next;

	// clear on read; an event in the read cycle starts the new count
	always_comb
	begin
		count_next = count_reg;
		if (clear_on_read)
			count_next = event_pulse ? 32'h0000_0001 : sepr_pkg::CNT_RESET;
		else if (event_pulse && count_reg != sepr_pkg::CNT_MAX)
			count_next = count_reg + 32'h0000_0001; // stops at all ones
	end

	// register
	always_ff @(posedge mclk)
	begin
		if (reset)
			count_reg <= sepr_pkg::CNT_RESET;
		else
			count_reg <= count_next;
	end

	assign count = count_reg;
endmodule

// ==== logic/sepr_regbank.sv ====
// register bank: port 2 filtered counter, priority remap tables, learn discard counters, irq gate
`timescale 1ns/1ps

module sepr_regbank
(
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// management register access
	input wire sepr_pkg::sepr_req_t mgmt_req,
	output logic [31:0] mgmt_rdata,
	output logic mgmt_rvalid,
	// switch engine events
	input wire logic port2_ingress_filtered,
	input wire logic port2_rate_limit_drop,
	input wire logic [2:0] learn_discard,
	input wire logic [15:0] engine_pending,
	// priority lookup
	input wire sepr_pkg::sepr_prio_req_t prio_req,
	output sepr_pkg::sepr_prio_rsp_t prio_rsp,
	// system interrupt request
	output logic engine_irq
);
	localparam int NP = sepr_pkg::NUM_PORTS;
	localparam int PW = sepr_pkg::PRIO_W;
	localparam int TW = sepr_pkg::TABLE_W;

	// pick one entry out of a table
	function automatic logic [2:0] remap_lookup(input logic [23:0] tbl, input logic [2:0] p);
		remap_lookup = tbl[p * PW +: PW];
	endfunction

	logic [TW-1:0] remap_reg [NP];
	logic [TW-1:0] remap_next [NP];
	logic gate_reg;
	logic gate_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic rvalid_reg;
	logic rvalid_next;
	sepr_pkg::sepr_prio_rsp_t prio_reg;
	sepr_pkg::sepr_prio_rsp_t prio_next;
	logic irq_reg;
	logic irq_next;

	logic [31:0] drop_cnt;
	logic [31:0] lrn_cnt [NP];
	logic drop_clr;
	logic [NP-1:0] lrn_clr;
	logic drop_evt;

	// only filter events count; rate-limit drops are tallied elsewhere
	assign drop_evt = port2_ingress_filtered & ~port2_rate_limit_drop;
	assign drop_clr = mgmt_req.rd && mgmt_req.idx == sepr_pkg::IDX_INGRESS_DROP_P2;

	// port 2 filtered counter
	sepr_sat_counter u_drop_cnt
	(
		.mclk(mclk),
		.reset(reset),
		.event_pulse(drop_evt),
		.clear_on_read(drop_clr),
		.count(drop_cnt)
	);

	// learn discard counters, one per port
	generate
		for (genvar g = 0; g < NP; g++)
		begin : g_lrn
			assign lrn_clr[g] = mgmt_req.rd
				&& mgmt_req.idx == sepr_pkg::IDX_UNLEARNED_P0 + 16'(g);
			sepr_sat_counter u_lrn_cnt
			(
				.mclk(mclk),
				.reset(reset),
				.event_pulse(learn_discard[g]),
				.clear_on_read(lrn_clr[g]),
				.count(lrn_cnt[g])
			);
		end
	endgenerate

	// register writes and read data
	always_comb
	begin
		for (int i = 0; i < NP; i++)
			remap_next[i] = remap_reg[i];
		gate_next = gate_reg;
		rdata_next = 32'h0000_0000;
		rvalid_next = mgmt_req.rd;
		if (mgmt_req.wr)
		begin
			for (int i = 0; i < NP; i++)
				if (mgmt_req.idx == sepr_pkg::IDX_REMAP_P0 + 16'(i))
					remap_next[i] = mgmt_req.wdata[TW-1:0];
			if (mgmt_req.idx == sepr_pkg::IDX_IRQ_GATE)
				gate_next = mgmt_req.wdata[sepr_pkg::IRQ_GATE_BIT];
		end
		if (mgmt_req.rd)
		begin
			unique case (mgmt_req.idx)
				sepr_pkg::IDX_INGRESS_DROP_P2: rdata_next = drop_cnt;
				sepr_pkg::IDX_REMAP_P0: rdata_next = {8'h00, remap_reg[0]};
				sepr_pkg::IDX_REMAP_P1: rdata_next = {8'h00, remap_reg[1]};
				sepr_pkg::IDX_REMAP_P2: rdata_next = {8'h00, remap_reg[2]};
				sepr_pkg::IDX_UNLEARNED_P0: rdata_next = lrn_cnt[0];
				sepr_pkg::IDX_UNLEARNED_P1: rdata_next = lrn_cnt[1];
				sepr_pkg::IDX_UNLEARNED_P2: rdata_next = lrn_cnt[2];
				sepr_pkg::IDX_IRQ_GATE: rdata_next = {31'h0000_0000, gate_reg};
				default: rdata_next = 32'h0000_0000; // unmapped reads zero
			endcase
		end
	end

	// priority remap toward egress queue selection
	always_comb
	begin
		prio_next.valid = prio_req.valid;
		prio_next.port = prio_req.port;
		prio_next.prio = prio_req.prio;
		if (prio_req.port < 2'(NP))
			prio_next.prio = remap_lookup(remap_reg[prio_req.port], prio_req.prio);
		else
			prio_next.valid = 1'b0; // no such port
	end

	// interrupt request: pending status is an input and is never touched here
	always_comb
	begin
		irq_next = (|engine_pending) & ~gate_reg;
	end

	// register all state
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			for (int i = 0; i < NP; i++)
				remap_reg[i] <= sepr_pkg::REMAP_RESET;
			gate_reg <= sepr_pkg::IRQ_GATE_RESET;
			rdata_reg <= 32'h0000_0000;
			rvalid_reg <= 1'b0;
			prio_reg <= '0;
			irq_reg <= 1'b0;
		end
		else
		begin
			for (int i = 0; i < NP; i++)
				remap_reg[i] <= remap_next[i];
			gate_reg <= gate_next;
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
			prio_reg <= prio_next;
			irq_reg <= irq_next;
		end
	end

	// outputs straight from flip-flops
	assign mgmt_rdata = rdata_reg;
	assign mgmt_rvalid = rvalid_reg;
	assign prio_rsp = prio_reg;
	assign engine_irq = irq_reg;
endmodule

// ==== dv/sepr_chk.sv ====
// port assertions for the remap and counter register bank
`timescale 1ns/1ps
module sepr_chk
(
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// watched ports
	input wire sepr_pkg::sepr_req_t mgmt_req,
	input wire logic [31:0] mgmt_rdata,
	input wire logic mgmt_rvalid,
	input wire logic [15:0] engine_pending,
	input wire sepr_pkg::sepr_prio_req_t prio_req,
	input wire sepr_pkg::sepr_prio_rsp_t prio_rsp,
	input wire logic engine_irq
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	property p_rv; mgmt_req.rd |=> mgmt_rvalid; endproperty
	a_rv: assert property (p_rv) else $error("read answer missing");
	property p_norv; !mgmt_req.rd |=> !mgmt_rvalid; endproperty
	a_norv: assert property (p_norv) else $error("stray read answer");
	property p_rzero; !mgmt_rvalid |-> mgmt_rdata == 32'h0000_0000; endproperty
	a_rzero: assert property (p_rzero) else $error("idle read data");
	property p_prsp; prio_req.valid && prio_req.port != 2'd3 |=> prio_rsp.valid; endproperty
	a_prsp: assert property (p_prsp) else $error("lookup answer missing");
	property p_pport; prio_rsp.valid |-> prio_rsp.port == $past(prio_req.port); endproperty
	a_pport: assert property (p_pport) else $error("lookup port wrong");
	property p_irq0; engine_pending == 16'h0000 |=> !engine_irq; endproperty
	a_irq0: assert property (p_irq0) else $error("irq without pending");
	property p_mask; mgmt_req.rd && mgmt_req.idx == 16'h1880 |=> mgmt_rdata[31:1] == '0; endproperty
	a_mask: assert property (p_mask) else $error("mask reserved bits");
	property p_tbl; mgmt_req.rd && mgmt_req.idx inside {[16'h1855:16'h1857]}
		|=> mgmt_rdata[31:24] == 8'h00; endproperty
	a_tbl: assert property (p_tbl) else $error("table reserved bits");
endmodule
bind sepr_regbank sepr_chk chk_u (.mclk, .reset, .mgmt_req, .mgmt_rdata, .mgmt_rvalid,
	.engine_pending, .prio_req, .prio_rsp, .engine_irq);

// ==== dv/sepr_regbank_tb.sv ====
// self-checking bench for the remap and counter register bank
`timescale 1ns/1ps
module sepr_regbank_tb;
	logic mclk = 0;
	logic reset = 1;
	sepr_pkg::sepr_req_t req = '0;
	sepr_pkg::sepr_prio_req_t preq = '0;
	sepr_pkg::sepr_prio_rsp_t prsp;
	logic [31:0] rdata;
	logic rvalid;
	logic irq;
	logic [4:0] evs = '0;
	logic [15:0] pend = '0;
	int n_fail = 0;
	int comparisons = 0;
	sepr_regbank dut_u (.mclk(mclk), .reset(reset), .mgmt_req(req), .mgmt_rdata(rdata),
		.mgmt_rvalid(rvalid), .port2_ingress_filtered(evs[4]), .port2_rate_limit_drop(evs[3]),
		.learn_discard(evs[2:0]), .engine_pending(pend), .prio_req(preq), .prio_rsp(prsp),
		.engine_irq(irq));
	// clock
	initial forever #4 mclk = ~mclk;
	task automatic conclude();
		if (n_fail == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			n_fail++;
			$display("mismatch %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic wr(logic [15:0] a, logic [31:0] d);
		@(posedge mclk) req <= '{1'b0, 1'b1, a, d};
		@(posedge mclk) req <= '0;
	endtask
	task automatic rd(logic [15:0] a, logic [31:0] e);
		@(posedge mclk) req <= '{1'b1, 1'b0, a, 32'h0000_0000};
		@(posedge mclk) req <= '0;
		#1 chk("rdata", e, rdata);
		chk("rvalid", 32'h0000_0001, {31'h0, rvalid});
	endtask
	task automatic lk(logic [1:0] p, logic [2:0] n, logic [2:0] e);
		@(posedge mclk) preq <= '{1'b1, p, n};
		@(posedge mclk) preq <= '0;
		#1 chk("pvalid", {31'h0, p != 2'd3}, {31'h0, prsp.valid});
		if (p != 2'd3)
		begin
			chk("prio", {29'h0, e}, {29'h0, prsp.prio});
			chk("pport", {30'h0, p}, {30'h0, prsp.port});
		end
	endtask
	// one event cycle: filtered, rate-limit, learn discard per port
	task automatic ev(logic [4:0] v);
		@(posedge mclk) evs <= v;
		@(posedge mclk) evs <= '0;
	endtask
	task automatic t_reset();
		for (int a = 'h1852; a <= 'h185a; a++)
			rd(16'(a), (a inside {['h1855:'h1857]}) ? 32'h00fa_c688 : '0);
		rd(16'h1880, 32'h0000_0001);
	endtask
	task automatic t_remap();
		for (int p = 0; p < 3; p++)
			for (int n = 0; n < 8; n++)
				lk(2'(p), 3'(n), 3'(n));
		wr(16'h1856, 32'hff05_3977);
		rd(16'h1856, 32'h0005_3977);
		for (int n = 0; n < 8; n++)
			lk(2'd1, 3'(n), 3'(7 - n));
		lk(2'd2, 3'd6, 3'd6);
		lk(2'd3, 3'd6, 3'd6);
	endtask
	task automatic t_count();
		ev(5'b10000);
		ev(5'b11000);
		ev(5'b10111);
		ev(5'b00110);
		ev(5'b00100);
		wr(16'h1859, 32'h0000_0007);
		rd(16'h1852, 32'h0000_0002);
		rd(16'h1852, 32'h0000_0000);
		rd(16'h1858, 32'h0000_0001);
		rd(16'h1859, 32'h0000_0002);
		rd(16'h185a, 32'h0000_0003);
		rd(16'h185a, 32'h0000_0000);
	endtask
	task automatic t_irq();
		@(posedge mclk) pend <= 16'h0100;
		repeat (3) @(posedge mclk);
		#1 chk("irq", 0, {31'h0, irq});
		wr(16'h1880, 32'h0000_0000);
		@(posedge mclk);
		#1 chk("irq", 1, {31'h0, irq});
		wr(16'h1880, 32'hffff_ffff);
		rd(16'h1880, 32'h0000_0001);
		chk("irq", 0, {31'h0, irq});
		@(posedge mclk) pend <= 16'h0000;
	endtask
	// main sequence
	initial
	begin
		repeat (10) @(posedge mclk);
		reset <= 1'b0;
		t_reset();
		t_remap();
		t_count();
		t_irq();
		conclude();
	end
	// hang guard
	initial
	begin
		repeat (2000) @(posedge mclk);
		n_fail++;
		conclude();
	end
endmodule
